/* src/smc_sleep_ctrl.sv */
// Overview of operation
// - Sleep needs armed bit plus sleep instruction
// - Mode 000 idle stops cpu, flash clocks
// - Idle wakes on any enabled interrupt
// - Halt four cycles after start-up, then run
// - Register file and static memory kept
// - Reset during sleep restarts at reset vector
// - Mode 001 stops io, cpu, flash clocks
// - Idle or quiet mode starts a conversion
// - Quiet mode wakes only on listed sources
// - Mode 010 power-down stops all clocks
// - Power-down wakes only on listed sources
// - Deep modes: line zero wakes by level
// - Power-down wake waits reset time-out
// - Mode 011 power-save keeps timer 2
// - Power-save timer 2 wake needs mask and global enable
// - Unused timer clocks stop; sync only timer
// - Brown-out off in deep modes when set
// - Brown-out re-enabled on every wake
// - Brown-out off extends wake to 60 us
// - Brown-out bit 6, timed enable write
// - Mode 110 standby, six cycle wake
// - Mode 111 extended standby, six cycles
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
module smc_sleep_ctrl #(
	parameter int STARTUP_CYCLES = smc_pkg::STARTUP_DEFAULT
) (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rstn_in,
	// AXI4-Lite write
	input  wire logic [7:0]            awaddr_in,
	input  wire logic                  awvalid_in,
	output logic                       awready_out,
	input  wire logic [31:0]           wdata_in,
	input  wire logic [3:0]            wstrb_in,
	input  wire logic                  wvalid_in,
	output logic                       wready_out,
	output logic [1:0]                 bresp_out,
	output logic                       bvalid_out,
	input  wire logic                  bready_in,
	// AXI4-Lite read
	input  wire logic [7:0]            araddr_in,
	input  wire logic                  arvalid_in,
	output logic                       arready_out,
	output logic [31:0]                rdata_out,
	output logic [1:0]                 rresp_out,
	output logic                       rvalid_out,
	input  wire logic                  rready_in,
	// Processor core
	input  wire logic                  sleep_instr_in,
	input  wire logic                  global_irq_en_in,
	input  wire logic                  cpu_reset_in,
	output logic                       cpu_halt_out,
	output logic                       wake_irq_out,
	// Peripherals and clock generator
	input  smc_pkg::smc_wake_s         wake_in,
	input  wire logic                  ext_crystal_in,
	input  wire logic                  conv_enable_in,
	input  wire logic                  t2_enable_in,
	input  wire logic                  t2_async_in,
	input  wire logic [1:0]            timer2_irq_mask_in,
	output smc_pkg::smc_clk_s          clk_gate_out,
	output logic                       conv_start_out,
	output logic                       bod_enable_out,
	output logic                       asleep_out
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SMC_RUN   = 2'b00,
		SMC_SLEEP = 2'b01,
		SMC_START = 2'b10,
		SMC_HALT  = 2'b11
	} smc_state_e;

	smc_state_e          state, next_state;
	smc_pkg::smc_mode_e  mode, next_mode;
	logic [7:0]          sleep_control, next_sleep_control;
	logic [7:0]          mcu_control, next_mcu_control;
	logic [2:0]          bod_win, next_bod_win;
	logic                bod_off, next_bod_off;
	logic                from_reset, next_from_reset;
	logic [2:0]          halt_cnt, next_halt_cnt;
	logic                conv_start, next_conv_start;
	logic                wake_irq, next_wake_irq;
	logic                aw_hold, next_aw_hold;
	logic                w_hold, next_w_hold;
	logic [7:0]          aw_addr, next_aw_addr;
	logic [31:0]         w_data, next_w_data;
	logic [3:0]          w_strb, next_w_strb;
	logic                bvalid, next_bvalid;
	logic [1:0]          bresp, next_bresp;
	logic                rvalid, next_rvalid;
	logic [1:0]          rresp, next_rresp;
	logic [31:0]         rdata, next_rdata;
	logic                wake, wake_reset, deep, bod_ok, tmr_start;
	logic [31:0]         tmr_count;
	logic                tmr_done;
	smc_pkg::smc_clk_s   gate;

	// ------------------------------------------------------------------
	// Wake timer
	// ------------------------------------------------------------------
	smc_wake_timer u_timer (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.start_in (tmr_start),
		.count_in (tmr_count),
		.done_out (tmr_done)
	);

	// ------------------------------------------------------------------
	// Wake decode
	// ------------------------------------------------------------------
	// Modes deeper than quiet, and brown-out eligible modes
	assign deep   = (mode != smc_pkg::SMC_IDLE) &&
			(mode != smc_pkg::SMC_QUIET);
	assign bod_ok = deep;

	// Enabled wake sources per mode
	always_comb begin
		logic t2w, lvl;
		t2w = global_irq_en_in && ((wake_in.t2_ovf && timer2_irq_mask_in[0])
			|| (wake_in.t2_cmp && timer2_irq_mask_in[1]));
		lvl = wake_in.ext0_level || wake_in.ext_other ||
			wake_in.pin_change;
		unique case (mode)
		smc_pkg::SMC_IDLE: wake = wake_in.any_irq;
		smc_pkg::SMC_QUIET: wake = wake_in.conv_done || wake_in.wdt_irq ||
			wake_in.tws_irq || wake_in.nvm_ready || lvl ||
			wake_in.t2_ovf || wake_in.t2_cmp;
		smc_pkg::SMC_PSAVE, smc_pkg::SMC_XSTANDBY: wake = wake_in.wdt_irq ||
			wake_in.tws_addr || lvl || (t2_enable_in && t2w);
		default: wake = wake_in.wdt_irq || wake_in.tws_addr || lvl;
		endcase
	end

	// Resets are handled by the core reset input
	assign wake_reset = cpu_reset_in;

	// Wake delay per mode
	always_comb begin
		if (bod_off)
			tmr_count = smc_pkg::BOD_WAKE_CYCLES;
		else if (mode == smc_pkg::SMC_STANDBY ||
			mode == smc_pkg::SMC_XSTANDBY)
			tmr_count = smc_pkg::STANDBY_CYCLES;
		else if (deep)
			tmr_count = STARTUP_CYCLES;
		else
			tmr_count = 32'h1;
	end

	// ------------------------------------------------------------------
	// Sleep sequencer
	// ------------------------------------------------------------------
	// Enter, wait for wake, time start-up, halt, release
	always_comb begin
		next_state      = state;
		next_mode       = mode;
		next_bod_off    = bod_off;
		next_from_reset = from_reset;
		next_halt_cnt   = halt_cnt;
		next_conv_start = 1'b0;
		next_wake_irq   = 1'b0;
		tmr_start       = 1'b0;
		unique case (state)
		SMC_RUN: begin
			if (sleep_instr_in && sleep_control[smc_pkg::SLEEP_ARM_POS]
				&& sleep_control[3:1] != 3'b100
				&& sleep_control[3:1] != 3'b101) begin
				next_state = SMC_SLEEP;
				next_mode  = smc_pkg::smc_mode_e'(sleep_control[3:1]);
				next_conv_start = conv_enable_in &&
					sleep_control[3:2] == 2'b00;
				next_bod_off = mcu_control[smc_pkg::BOD_OFF_POS] &&
					sleep_control[2];
			end
		end
		SMC_SLEEP: begin
			if (wake_reset || wake) begin
				next_state      = SMC_START;
				next_from_reset = wake_reset;
				tmr_start       = 1'b1;
			end
		end
		SMC_START: begin
			if (tmr_done) begin
				next_bod_off  = 1'b0;
				next_state    = SMC_HALT;
				next_halt_cnt = 3'(smc_pkg::HALT_CYCLES);
			end
		end
		SMC_HALT: begin
			next_halt_cnt = halt_cnt - 3'h1;
			if (halt_cnt == 3'h1) begin
				next_state    = SMC_RUN;
				next_wake_irq = !from_reset;
			end
		end
		endcase
	end

	// Registers
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state      <= SMC_RUN;
			mode       <= smc_pkg::SMC_IDLE;
			bod_off    <= 1'b0;
			from_reset <= 1'b0;
			halt_cnt   <= 3'h0;
			conv_start <= 1'b0;
			wake_irq   <= 1'b0;
		end else begin
			state      <= next_state;
			mode       <= next_mode;
			bod_off    <= next_bod_off;
			from_reset <= next_from_reset;
			halt_cnt   <= next_halt_cnt;
			conv_start <= next_conv_start;
			wake_irq   <= next_wake_irq;
		end
	end

	// ------------------------------------------------------------------
	// Clock gating
	// ------------------------------------------------------------------
	// Memories are never cleared here, only their clocks stop
	always_comb begin
		gate = '1;
		if (state != SMC_RUN) begin
			gate.cpu   = 1'b0;
			gate.flash = 1'b0;
			// While asleep, timer oscillator runs only for an asynchronous timer 2
			if (state == SMC_SLEEP)
				gate.tosc = t2_enable_in && t2_async_in;
			if (state == SMC_SLEEP && mode != smc_pkg::SMC_IDLE) begin
				gate.io = 1'b0;
				if (deep) begin
					gate.conv = 1'b0;
					gate.asy  = 1'b0;
					gate.osc  = mode[2];
					gate.tosc = 1'b0;
					gate.t2_sync = 1'b0;
					if (mode[0] && t2_enable_in) begin
						gate.asy  = t2_async_in;
						gate.tosc = t2_async_in;
						gate.t2_sync = !t2_async_in;
						gate.osc  = mode[2] || !t2_async_in;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------
	// Address and data taken in either order, answer when both held
	always_comb begin
		logic wr_go, st_ok;
		next_aw_hold = aw_hold;
		next_w_hold  = w_hold;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid && !bready_in;
		next_bresp   = bresp;
		next_rvalid  = rvalid && !rready_in;
		next_rresp   = rresp;
		next_rdata   = rdata;
		next_sleep_control = sleep_control;
		next_mcu_control   = mcu_control;
		next_bod_win = (bod_win != 3'h0) ? bod_win - 3'h1 : 3'h0;
		st_ok = 1'b0;
		if (awvalid_in && !aw_hold) begin
			next_aw_hold = 1'b1;
			next_aw_addr = awaddr_in;
		end
		if (wvalid_in && !w_hold) begin
			next_w_hold = 1'b1;
			next_w_data = wdata_in;
			next_w_strb = wstrb_in;
		end
		wr_go = aw_hold && w_hold && !bvalid;
		if (wr_go) begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = 2'b00;
			unique case (aw_addr)
			smc_pkg::SLEEP_CONTROL_OFS:
				if (w_strb[0])
					next_sleep_control = {4'h0, w_data[3:0]};
			smc_pkg::MCU_CONTROL_OFS:
				if (w_strb[0]) begin
					// Enable written with the off bit opens a short window for the off bit
					if (w_data[smc_pkg::BOD_WEN_POS] &&
						w_data[smc_pkg::BOD_OFF_POS]) begin
						next_bod_win = 3'(smc_pkg::BOD_WEN_WINDOW);
						next_mcu_control = 8'h00;
					end else if (bod_win != 3'h0) begin
						next_mcu_control = {1'b0,
							w_data[smc_pkg::BOD_OFF_POS], 6'h00};
						next_bod_win = 3'h0;
					end else begin
						next_mcu_control = 8'h00;
					end
				end
			default: next_bresp = 2'b10;
			endcase
		end
		if (arvalid_in && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp  = 2'b00;
			unique case (araddr_in)
			smc_pkg::SLEEP_CONTROL_OFS: next_rdata = {24'h0, sleep_control};
			smc_pkg::MCU_CONTROL_OFS:   next_rdata = {24'h0, mcu_control};
			smc_pkg::STATUS_OFS: next_rdata = {27'h0, bod_off, mode, st_ok};
			default: begin
				next_rdata = 32'h0;
				next_rresp = 2'b10;
			end
			endcase
		end
	end

	// Registers
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= 2'b00;
			rvalid  <= 1'b0;
			rresp   <= 2'b00;
			rdata   <= 32'h0;
			sleep_control <= smc_pkg::SLEEP_CONTROL_RST;
			mcu_control   <= smc_pkg::MCU_CONTROL_RST;
			bod_win <= 3'h0;
		end else begin
			aw_hold <= next_aw_hold;
			w_hold  <= next_w_hold;
			aw_addr <= next_aw_addr;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rresp   <= next_rresp;
			rdata   <= next_rdata;
			sleep_control <= next_sleep_control;
			mcu_control   <= next_mcu_control;
			bod_win <= next_bod_win;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign awready_out    = !aw_hold;
	assign wready_out     = !w_hold;
	assign bvalid_out     = bvalid;
	assign bresp_out      = bresp;
	assign arready_out    = !rvalid;
	assign rvalid_out     = rvalid;
	assign rresp_out      = rresp;
	assign rdata_out      = rdata;
	assign cpu_halt_out   = (state != SMC_RUN);
	assign wake_irq_out   = wake_irq;
	assign clk_gate_out   = gate;
	assign conv_start_out = conv_start;
	assign bod_enable_out = !(bod_off && state == SMC_SLEEP);
	assign asleep_out     = (state == SMC_SLEEP);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence halt_seq;
		cpu_halt_out [*4];
	endsequence

	noop_sleep_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		state == SMC_RUN && sleep_instr_in &&
		!sleep_control[0] |=> state == SMC_RUN)
		else $error("Unarmed sleep entered a mode");
	arm_sleep_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$rose(asleep_out) |-> $past(sleep_control[0]))
		else $error("Sleep without arm bit");
	idle_clock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		asleep_out && mode == smc_pkg::SMC_IDLE |->
		!clk_gate_out.cpu && clk_gate_out.io)
		else $error("Idle clock gating wrong");
	quiet_clock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		asleep_out && mode == smc_pkg::SMC_QUIET |->
		!clk_gate_out.io && clk_gate_out.conv)
		else $error("Quiet mode clock gating wrong");
	pdown_clock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		asleep_out && mode == smc_pkg::SMC_PDOWN |->
		!clk_gate_out.osc && !clk_gate_out.asy)
		else $error("Power-down left a clock running");
	halt_four_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		state == SMC_START && tmr_done |=> halt_seq ##1 !cpu_halt_out)
		else $error("Halt not four cycles");
	bod_back_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(cpu_halt_out) |-> !bod_off && bod_enable_out)
		else $error("Brown-out not re-enabled");
	conv_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		conv_start_out |-> asleep_out && !deep)
		else $error("Conversion start in wrong mode");
	idle_wake_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		asleep_out && mode == smc_pkg::SMC_IDLE && wake_in.any_irq
		|=> state == SMC_START)
		else $error("Idle did not wake");

endmodule

/* inc/smc_pkg.sv */
package smc_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] SLEEP_CONTROL_OFS = 8'h00;
	localparam logic [7:0] MCU_CONTROL_OFS   = 8'h04;
	localparam logic [7:0] WAKE_CONFIG_OFS   = 8'h08;
	localparam logic [7:0] STATUS_OFS        = 8'h0c;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int         SLEEP_ARM_POS      = 0;
	localparam int         SLEEP_SEL_LSB      = 1;
	localparam int         BOD_OFF_POS        = 6;
	localparam int         BOD_WEN_POS        = 5;
	localparam logic [7:0] SLEEP_CONTROL_RST  = 8'h00;
	localparam logic [7:0] MCU_CONTROL_RST    = 8'h00;
	localparam logic [7:0] WAKE_CONFIG_RST    = 8'h00;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ           = 200;
	localparam int HALT_CYCLES       = 4;
	localparam int STANDBY_CYCLES    = 6;
	localparam int BOD_WAKE_US       = 60;
	localparam int BOD_WAKE_CYCLES   = BOD_WAKE_US * CLK_MHZ;
	localparam int BOD_WEN_WINDOW    = 4;
	localparam int STARTUP_DEFAULT   = 16384;

	// ------------------------------------------------------------------
	// Sleep mode codes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		SMC_IDLE     = 3'b000,
		SMC_QUIET    = 3'b001,
		SMC_PDOWN    = 3'b010,
		SMC_PSAVE    = 3'b011,
		SMC_RSV4     = 3'b100,
		SMC_RSV5     = 3'b101,
		SMC_STANDBY  = 3'b110,
		SMC_XSTANDBY = 3'b111
	} smc_mode_e;

	// Clock domain gates, high = running
	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic conv;
		logic asy;
		logic osc;
		logic tosc;
		logic t2_sync;
	} smc_clk_s;

	// Wake sources from peripherals
	typedef struct packed {
		logic any_irq;
		logic conv_done;
		logic wdt_irq;
		logic tws_irq;
		logic tws_addr;
		logic t2_ovf;
		logic t2_cmp;
		logic nvm_ready;
		logic ext0_level;
		logic ext0_edge;
		logic ext_other;
		logic pin_change;
	} smc_wake_s;

endpackage

/* src/smc_wake_timer.sv */
// Down counter that times the wake-up delay
module smc_wake_timer (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	// Control
	input  wire logic        start_in,
	input  wire logic [31:0] count_in,
	// Status
	output logic             done_out
);

	logic [31:0] count;
	logic [31:0] next_count;
	logic        busy;
	logic        next_busy;
	logic        done;
	logic        next_done;

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	// Load on start, pulse done when the count expires
	always_comb begin
		next_count = count;
		next_busy  = busy;
		next_done  = 1'b0;
		if (start_in) begin
			next_count = count_in;
			next_busy  = 1'b1;
		end else if (busy) begin
			if (count <= 32'h1) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end else begin
				next_count = count - 32'h1;
			end
		end
	end

	// Registers
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count <= 32'h0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			count <= next_count;
			busy  <= next_busy;
			done  <= next_done;
		end
	end

	assign done_out = done;

endmodule

/* testbench/smc_core_model.sv */
// ------------------------------------------------------------------
// Core and wake-source model
// ------------------------------------------------------------------
module smc_core_model (
	// Clock and reset
	input  wire logic          clk_in,
	input  wire logic          rstn_in,
	// Bench requests
	input  wire logic          sleep_req_in,
	input  smc_pkg::smc_wake_s wake_req_in,
	input  wire logic          wake_drop_in,
	// Block status
	input  wire logic          cpu_halt_in,
	input  wire logic          asleep_in,
	// Core and sources
	output logic               sleep_instr_out,
	output smc_pkg::smc_wake_s wake_out
);
	logic               next_instr;
	smc_pkg::smc_wake_s next_wake;

	// A halted core cannot issue; a source holds until it is seen
	always_comb begin
		next_instr = sleep_req_in && !cpu_halt_in;
		next_wake = (asleep_in && !wake_drop_in) ? wake_out : '0;
		if (wake_req_in != '0)
			next_wake = wake_req_in;
	end

	// Register the core and source outputs
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sleep_instr_out <= 1'b0;
			wake_out        <= '0;
		end else begin
			sleep_instr_out <= next_instr;
			wake_out        <= next_wake;
		end
	end
endmodule

/* testbench/sleep_mode_controller_tb.sv */
module sleep_mode_controller_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int N = 20;
	logic               clk_in, rstn_in, awvalid, awready, wvalid, wready;
	logic               bvalid, arvalid, arready, rvalid, sleep_instr;
	logic               gie, cpu_reset, halt, wirq, xtal, conv_en, t2e;
	logic               t2a, conv_start, bod_en, asleep, sleep_req, drop;
	logic [7:0]         awaddr, araddr;
	logic [31:0]        wdata, rdata;
	logic [1:0]         bresp, rresp, t2_mask;
	smc_pkg::smc_wake_s wake, wake_req;
	smc_pkg::smc_clk_s  gates;
	int                 error_cnt, total_checks, seed, irq_cnt, conv_cnt;
	logic [2:0]         tbl [6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd6, 3'd7};

	// ------------------------------------------------------------------
	// Design and partner
	// ------------------------------------------------------------------
	smc_sleep_ctrl #(.STARTUP_CYCLES(N)) i_dut (.clk_in(clk_in),
		.rstn_in(rstn_in), .awaddr_in(awaddr), .awvalid_in(awvalid),
		.awready_out(awready), .wdata_in(wdata), .wstrb_in(4'hf),
		.wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
		.bvalid_out(bvalid), .bready_in(1'b1), .araddr_in(araddr),
		.arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
		.rresp_out(rresp), .rvalid_out(rvalid), .rready_in(1'b1),
		.sleep_instr_in(sleep_instr), .global_irq_en_in(gie),
		.cpu_reset_in(cpu_reset), .cpu_halt_out(halt),
		.wake_irq_out(wirq), .wake_in(wake), .ext_crystal_in(xtal),
		.conv_enable_in(conv_en), .t2_enable_in(t2e), .t2_async_in(t2a),
		.timer2_irq_mask_in(t2_mask), .clk_gate_out(gates),
		.conv_start_out(conv_start), .bod_enable_out(bod_en),
		.asleep_out(asleep));
	smc_core_model i_core (.clk_in(clk_in), .rstn_in(rstn_in),
		.sleep_req_in(sleep_req), .wake_req_in(wake_req),
		.wake_drop_in(drop), .cpu_halt_in(halt), .asleep_in(asleep),
		.sleep_instr_out(sleep_instr), .wake_out(wake));

	// 200 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// Count one-cycle pulses
	always @(negedge clk_in) begin
		if (wirq === 1'b1) irq_cnt++;
		if (conv_start === 1'b1) conv_cnt++;
	end

	// ------------------------------------------------------------------
	// Tasks and expectations
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Bus tasks start just after an edge and end on one
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w, b;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge clk_in);
			aw = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			r = bresp;
			@(posedge clk_in);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (b !== 1'b1);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar, v;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge clk_in);
			ar = arvalid & arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_in);
			if (ar) arvalid <= 1'b0;
		end while (v !== 1'b1);
	endtask

	// Expected {cpu,flash,io,conv,osc,tosc} while asleep
	function automatic logic [5:0] exp_g(logic [2:0] m, logic e, logic a);
		logic t;
		t = (m == 3'd0 || m == 3'd1 || m == 3'd3 || m == 3'd7) && e && a;
		case (m)
			3'd0: return {5'b00111, t};
			3'd1: return {5'b00011, t};
			3'd3: return {4'b0000, e && !a, t};
			3'd6, 3'd7: return {5'b00001, t};
			default: return 6'b000000;
		endcase
	endfunction

	function automatic int exp_wait(logic [2:0] m, logic bo);
		if (bo && m[1]) return smc_pkg::BOD_WAKE_CYCLES;
		if (m[1]) return m[2] ? smc_pkg::STANDBY_CYCLES : N;
		return 1;
	endfunction

	task automatic enter(input logic [2:0] m, input logic bo);
		logic [1:0] r;
		int c;
		axw(smc_pkg::SLEEP_CONTROL_OFS, {28'h0, m, 1'b1}, r);
		c = conv_cnt;
		sleep_req <= 1'b1;
		@(posedge clk_in) sleep_req <= 1'b0;
		repeat (5) @(negedge clk_in);
		chk("asleep", asleep, 1);
		chk("gates", {gates.cpu, gates.flash, gates.io, gates.conv,
			gates.osc, gates.tosc}, exp_g(m, t2e, t2a));
		chk("bod_off", bod_en, !(bo && m[1]));
		chk("conv_start", conv_cnt - c, m < 3'd2 && conv_en);
		@(posedge clk_in);
	endtask

	task automatic wake_up(input logic [2:0] m, input logic bo,
		input smc_pkg::smc_wake_s s);
		int n, w;
		w = exp_wait(m, bo) + smc_pkg::HALT_CYCLES;
		wake_req <= s;
		@(posedge clk_in) wake_req <= '0;
		n = 1;
		while (wirq !== 1'b1 && n < 13000) begin
			@(negedge clk_in);
			n++;
		end
		chk("wake_time", n >= w && n <= w + 4, 1);
		chk("halt_after", halt, 0);
		chk("bod_back", bod_en, 1);
		@(posedge clk_in);
	endtask

	task automatic no_wake(input smc_pkg::smc_wake_s s);
		wake_req <= s;
		@(posedge clk_in) wake_req <= '0;
		repeat (40) @(negedge clk_in);
		chk("no_wake", asleep, 1);
		@(posedge clk_in) drop <= 1'b1;
		@(posedge clk_in) drop <= 1'b0;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0]        d;
		logic [1:0]         r;
		logic [2:0]         m;
		int                 i, c;
		smc_pkg::smc_wake_s s;
		{awvalid, wvalid, arvalid, sleep_req, drop, cpu_reset} = '0;
		{awaddr, araddr, wdata, t2_mask, gie} = '0;
		{wake_req, t2e, t2a, rstn_in} = '0;
		{xtal, conv_en} = 2'b11;
		seed = 32'ha192;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		for (i = 0; i < 4; i++) begin
			axr(8'(i * 4), d, r);
			chk("reset_data", d, 0);
			chk("resp", r, (i == 2) ? 2'b10 : 2'b00);
		end
		chk("rst_gates", gates, 8'hff);
		chk("rst_bod", bod_en, 1);
		// Unarmed, then armed with a reserved mode: both are ignored
		for (i = 0; i < 2; i++) begin
			axw(smc_pkg::SLEEP_CONTROL_OFS, (i != 0) ? 32'h9 : 32'h4, r);
			sleep_req <= 1'b1;
			@(posedge clk_in) sleep_req <= 1'b0;
			repeat (5) @(negedge clk_in);
			chk("unarmed", {asleep, gates}, 9'h0ff);
			@(posedge clk_in);
		end
		axw(smc_pkg::MCU_CONTROL_OFS, 32'h40, r);
		chk("wresp", r, 2'b00);
		axr(smc_pkg::MCU_CONTROL_OFS, d, r);
		chk("bod_untimed", d[6], 0);
		axw(smc_pkg::WAKE_CONFIG_OFS, 32'h0, r);
		chk("wresp_bad", r, 2'b10);
		axw(smc_pkg::MCU_CONTROL_OFS, 32'h60, r);
		axw(smc_pkg::MCU_CONTROL_OFS, 32'h40, r);
		axr(smc_pkg::MCU_CONTROL_OFS, d, r);
		chk("bod_timed", d[6], 1);
		s = '0;
		s.any_irq = 1'b1;
		enter(3'd0, 1'b1);
		wake_up(3'd0, 1'b1, s);
		s = '0;
		s.pin_change = 1'b1;
		enter(3'd2, 1'b1);
		wake_up(3'd2, 1'b1, s);
		axw(smc_pkg::MCU_CONTROL_OFS, 32'h60, r);
		axw(smc_pkg::MCU_CONTROL_OFS, 32'h00, r);
		for (i = 0; i < 14; i++) begin
			m = tbl[(i < 6) ? i : $unsigned($random(seed)) % 6];
			conv_en <= 1'($random(seed));
			t2e <= 1'($random(seed));
			t2a <= 1'($random(seed));
			@(posedge clk_in);
			s = '0;
			s.any_irq = (m == 3'd0);
			s.pin_change = (m != 3'd0);
			enter(m, 1'b0);
			wake_up(m, 1'b0, s);
		end
		enter(3'd2, 1'b0);
		s = '0;
		s.ext0_edge = 1'b1;
		no_wake(s);
		s = '0;
		s.ext0_level = 1'b1;
		wake_up(3'd2, 1'b0, s);
		{t2e, t2a} <= 2'b11;
		@(posedge clk_in);
		enter(3'd3, 1'b0);
		s = '0;
		s.t2_ovf = 1'b1;
		no_wake(s);
		gie <= 1'b1;
		t2_mask <= 2'b01;
		wake_up(3'd3, 1'b0, s);
		enter(3'd2, 1'b0);
		c = irq_cnt;
		cpu_reset <= 1'b1;
		@(posedge clk_in) cpu_reset <= 1'b0;
		repeat (N + 20) @(negedge clk_in);
		chk("reset_wake", {asleep, halt}, 0);
		chk("reset_no_irq", irq_cnt - c, 0);
		finish_test();
	end

	// Cut a hang short
	initial begin
		repeat (60000) @(posedge clk_in);
		error_cnt++;
		finish_test();
	end
endmodule
